// ==== clock_gate_pkg.sv ====
// constants for the peripheral clock gating block
package clock_gate_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_RUN_GATE    = 12'h104;
    localparam logic [11:0] OFF_SLEEP_GATE  = 12'h114;
    localparam logic [11:0] OFF_DEEP_GATE   = 12'h124;
    localparam logic [11:0] OFF_RUN_CFG     = 12'h060;
    localparam logic [11:0] OFF_POWER_STATE = 12'h800;
    localparam logic [11:0] OFF_IRQ_STATUS  = 12'h804;
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h808;
    localparam logic [11:0] OFF_FAULT_INFO  = 12'h80C;
    // reset values
    localparam logic [31:0] GATE_RESET      = 32'h00000000;
    // writable gate bits: cmp 25:24, counters 19:16, two-wire 14,12, sync 5:4, async 2:0
    localparam logic [31:0] GATE_WMASK      = 32'h030F5037;
    localparam int          NUM_UNITS       = 13;
    // bit position of each unit, unit index order
    localparam int          UNIT_BIT [NUM_UNITS] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};
    // run clock configuration field
    localparam int          AUTO_GATING_BIT = 27;
    // power states
    localparam logic [1:0]  PWR_RUN         = 2'h0;
    localparam logic [1:0]  PWR_SLEEP       = 2'h1;
    localparam logic [1:0]  PWR_DEEP        = 2'h2;
    // interrupt status bits
    localparam int          IRQ_FAULT_BIT   = 0;
    localparam int          IRQ_STATE_BIT   = 1;
    localparam logic [1:0]  IRQ_WMASK       = 2'h3;
    // ahb codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    localparam logic        HRESP_OKAY      = 1'b0;
endpackage : clock_gate_pkg

// ==== peripheral_clock_gating.sv ====
// per-peripheral clock gate control with ahb-lite register slave
// Function
// - bits 18, 17, 16 gate general-purpose counters 2, 1, 0
// - bit 14 gates two-wire unit 1, bit 12 two-wire unit 0
// - bit 5 gates sync serial unit 1, bit 4 unit 0
// - bits 2, 1, 0 gate async serial units 2, 1, 0
// - bit one clocks the unit, bit zero stops its clock
// - access to a gated-off unit raises unit_fault a cycle later; hresp stays okay
// - all gate bits reset to zero, every unit unclocked
// - reserved bits are read-only zero; software preserves them
// - separate run, sleep and deep-sleep gate registers of same layout
// - sleep registers apply only when auto gating select is set
// - deep-sleep gate register at 0x124, reset 0x00000000
// - gate positions without a unit have no effect
// - bits 25, 24 gate comparators b, a; bit 19 counter 3
// - sleep gate register at 0x114, reset 0x00000000
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module peripheral_clock_gating
    import clock_gate_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [11:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire logic [31:0]          hwdata,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // peripheral access watch: one select per unit, in unit index order
    input  wire logic [NUM_UNITS-1:0] unit_access,
    output logic                      unit_fault,
    // gated peripheral clocks and current enables
    output logic [NUM_UNITS-1:0]      unit_clk,
    output logic [31:0]               gate_enable,
    // interrupt
    output logic                      irq
);
    logic [31:0] run_gate_reg_1_r, run_gate_reg_1_nxt;
    logic [31:0] sleep_gate_reg_1_r, sleep_gate_reg_1_nxt;
    logic [31:0] deep_sleep_gate_reg_1_r, deep_sleep_gate_reg_1_nxt;
    logic [31:0] run_clock_config_reg_r, run_clock_config_reg_nxt;
    logic [1:0]  power_state_r, power_state_nxt;
    logic [1:0]  irq_status_r, irq_status_nxt;
    logic [1:0]  irq_mask_r, irq_mask_nxt;
    logic [NUM_UNITS-1:0] fault_info_r, fault_info_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] gate_sel;
    logic [31:0] gate_enable_r, gate_enable_nxt;
    logic        fault_r, fault_nxt;
    logic        take;
    logic        auto_gating_select;
    logic [NUM_UNITS-1:0] unit_en;
    logic [NUM_UNITS-1:0] unit_hit;

    assign take               = hsel && hready && htrans == HTRANS_NONSEQ;
    assign auto_gating_select = run_clock_config_reg_r[AUTO_GATING_BIT];
    assign hreadyout          = 1'b1;
    assign hresp              = HRESP_OKAY;

    // enable source follows power state; sleep sets only with auto gating
    always_comb begin
        gate_sel = run_gate_reg_1_r;
        if (auto_gating_select) begin
            if (power_state_r == PWR_SLEEP) begin
                gate_sel = sleep_gate_reg_1_r;
            end else if (power_state_r == PWR_DEEP) begin
                gate_sel = deep_sleep_gate_reg_1_r;
            end
        end
        gate_enable_nxt = gate_sel & GATE_WMASK;
    end

    // per-unit latch-based gate: enable captured while clock low, so no glitch
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        logic en_lat;
        always_latch begin
            if (!clk) begin
                en_lat = gate_enable_r[UNIT_BIT[u]];
            end
        end
        assign unit_en[u]  = gate_enable_r[UNIT_BIT[u]];
        assign unit_clk[u] = clk & en_lat;
        assign unit_hit[u] = unit_access[u] & ~unit_en[u];
    end
    assign gate_enable = gate_enable_r;
    assign fault_nxt   = |unit_hit;
    assign unit_fault  = fault_r;

    // register slave: address phase captured, write committed in data phase
    always_comb begin
        run_gate_reg_1_nxt        = run_gate_reg_1_r;
        sleep_gate_reg_1_nxt      = sleep_gate_reg_1_r;
        deep_sleep_gate_reg_1_nxt = deep_sleep_gate_reg_1_r;
        run_clock_config_reg_nxt  = run_clock_config_reg_r;
        power_state_nxt           = power_state_r;
        irq_mask_nxt              = irq_mask_r;
        irq_status_nxt            = irq_status_r;
        fault_info_nxt            = fault_info_r;
        wr_pend_nxt               = take && hwrite && hsize == HSIZE_WORD;
        addr_nxt                  = take ? haddr : addr_r;
        rdata_nxt                 = rdata_r;
        if (wr_pend_r) begin
            case (addr_r)
                OFF_RUN_GATE:    run_gate_reg_1_nxt        = hwdata & GATE_WMASK;
                OFF_SLEEP_GATE:  sleep_gate_reg_1_nxt      = hwdata & GATE_WMASK;
                OFF_DEEP_GATE:   deep_sleep_gate_reg_1_nxt = hwdata & GATE_WMASK;
                OFF_RUN_CFG:     run_clock_config_reg_nxt  = hwdata;
                OFF_POWER_STATE: power_state_nxt           = hwdata[1:0];
                OFF_IRQ_MASK:    irq_mask_nxt              = hwdata[1:0] & IRQ_WMASK;
                OFF_IRQ_STATUS:  irq_status_nxt            = irq_status_r & ~hwdata[1:0];
                default: ;
            endcase
        end
        // set wins over a simultaneous clear
        if (fault_nxt) begin
            irq_status_nxt[IRQ_FAULT_BIT] = 1'b1;
            fault_info_nxt                = fault_info_r | unit_hit;
        end
        if (gate_enable_nxt != gate_enable_r) begin
            irq_status_nxt[IRQ_STATE_BIT] = 1'b1;
        end
        if (take && !hwrite) begin
            case (haddr)
                OFF_RUN_GATE:    rdata_nxt = run_gate_reg_1_r;
                OFF_SLEEP_GATE:  rdata_nxt = sleep_gate_reg_1_r;
                OFF_DEEP_GATE:   rdata_nxt = deep_sleep_gate_reg_1_r;
                OFF_RUN_CFG:     rdata_nxt = run_clock_config_reg_r;
                OFF_POWER_STATE: rdata_nxt = {30'h0, power_state_r};
                OFF_IRQ_STATUS:  rdata_nxt = {30'h0, irq_status_r};
                OFF_IRQ_MASK:    rdata_nxt = {30'h0, irq_mask_r};
                OFF_FAULT_INFO:  rdata_nxt = {19'h0, fault_info_r};
                default:         rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_gate_reg_1_r        <= GATE_RESET;
            sleep_gate_reg_1_r      <= GATE_RESET;
            deep_sleep_gate_reg_1_r <= GATE_RESET;
            run_clock_config_reg_r  <= 32'h00000000;
            power_state_r           <= PWR_RUN;
            irq_status_r            <= 2'h0;
            irq_mask_r              <= 2'h0;
            fault_info_r            <= '0;
            wr_pend_r               <= 1'b0;
            addr_r                  <= 12'h000;
            rdata_r                 <= 32'h00000000;
            gate_enable_r           <= GATE_RESET;
            fault_r                 <= 1'b0;
        end else begin
            run_gate_reg_1_r        <= run_gate_reg_1_nxt;
            sleep_gate_reg_1_r      <= sleep_gate_reg_1_nxt;
            deep_sleep_gate_reg_1_r <= deep_sleep_gate_reg_1_nxt;
            run_clock_config_reg_r  <= run_clock_config_reg_nxt;
            power_state_r           <= power_state_nxt;
            irq_status_r            <= irq_status_nxt;
            irq_mask_r              <= irq_mask_nxt;
            fault_info_r            <= fault_info_nxt;
            wr_pend_r               <= wr_pend_nxt;
            addr_r                  <= addr_nxt;
            rdata_r                 <= rdata_nxt;
            gate_enable_r           <= gate_enable_nxt;
            fault_r                 <= fault_nxt;
        end
    end

    assign hrdata = rdata_r;
    assign irq    = |(irq_status_r & irq_mask_r);

    // checks: reset state, sampled while reset is held
    chk_reset_gates: assert property (@(posedge clk)
        !resetn |-> gate_enable == GATE_RESET && !irq && hrdata == 32'h00000000)
        else $error("gates not cleared by reset");

    // reserved positions never reach storage or the applied set
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        (gate_enable & ~GATE_WMASK) == 32'h0)
        else $error("reserved gate bit set");
    chk_reserved_store: assert property (@(posedge clk) disable iff (!resetn)
        ((run_gate_reg_1_r | sleep_gate_reg_1_r | deep_sleep_gate_reg_1_r) & ~GATE_WMASK) == 32'h0)
        else $error("reserved bit stored");

    // unit clock mapping per bit position
    chk_counter_bits: assert property (@(posedge clk) disable iff (!resetn)
        unit_en[9:7] == gate_enable[18:16])
        else $error("counter gate mapping wrong");
    chk_two_wire_bits: assert property (@(posedge clk) disable iff (!resetn)
        unit_en[6:5] == {gate_enable[14], gate_enable[12]})
        else $error("two-wire gate mapping wrong");
    chk_sync_bits: assert property (@(posedge clk) disable iff (!resetn)
        unit_en[4:3] == gate_enable[5:4])
        else $error("sync serial gate mapping wrong");
    chk_async_bits: assert property (@(posedge clk) disable iff (!resetn)
        unit_en[2:0] == gate_enable[2:0])
        else $error("async serial gate mapping wrong");
    chk_cmp_bits: assert property (@(posedge clk) disable iff (!resetn)
        unit_en[12:10] == {gate_enable[25:24], gate_enable[19]})
        else $error("comparator gate mapping wrong");

    // faults on gated-off units
    chk_fault_on_gated: assert property (@(posedge clk) disable iff (!resetn)
        (unit_access[0] && !gate_enable[0]) |=> unit_fault)
        else $error("missing fault on gated access");
    chk_hit_units: assert property (@(posedge clk) disable iff (!resetn)
        (unit_access & ~unit_en) != '0
        |=> unit_fault)
        else $error("missing fault on some gated unit");
    chk_no_fault_open: assert property (@(posedge clk) disable iff (!resetn)
        ((unit_access & unit_en) == unit_access) |=> !unit_fault)
        else $error("fault on clocked unit");
    chk_fault_sticky: assert property (@(posedge clk) disable iff (!resetn)
        unit_fault |=> irq_status_r[IRQ_FAULT_BIT])
        else $error("fault status not set");
    chk_fault_record: assert property (@(posedge clk) disable iff (!resetn)
        unit_fault |-> fault_info_r != '0)
        else $error("fault unit not recorded");

    // set selection by power state
    chk_run_select: assert property (@(posedge clk) disable iff (!resetn)
        !auto_gating_select |=> gate_enable == $past(run_gate_reg_1_r & GATE_WMASK))
        else $error("gates left run set without auto gating");
    chk_sleep_select: assert property (@(posedge clk) disable iff (!resetn)
        (auto_gating_select && power_state_r == PWR_SLEEP)
        |=> gate_enable == $past(sleep_gate_reg_1_r & GATE_WMASK))
        else $error("sleep set not applied");
    chk_deep_select: assert property (@(posedge clk) disable iff (!resetn)
        (auto_gating_select && power_state_r == PWR_DEEP)
        |=> gate_enable == $past(deep_sleep_gate_reg_1_r & GATE_WMASK))
        else $error("deep sleep set not applied");
    chk_state_event: assert property (@(posedge clk) disable iff (!resetn)
        (gate_enable_nxt != gate_enable_r)
        |=> irq_status_r[IRQ_STATE_BIT])
        else $error("enable change not flagged");
    chk_enable_hold: assert property (@(posedge clk) disable iff (!resetn)
        (gate_enable_nxt == gate_enable_r)
        |=> $stable(gate_enable))
        else $error("enables moved without a new set");

    // register writes and reads
    chk_run_write: assert property (@(posedge clk) disable iff (!resetn)
        (wr_pend_r && addr_r == OFF_RUN_GATE)
        |=> run_gate_reg_1_r == ($past(hwdata) & GATE_WMASK))
        else $error("run write lost");
    chk_deep_write: assert property (@(posedge clk) disable iff (!resetn)
        (wr_pend_r && addr_r == OFF_DEEP_GATE)
        |=> deep_sleep_gate_reg_1_r == ($past(hwdata) & GATE_WMASK))
        else $error("deep sleep write lost");
    chk_sleep_write: assert property (@(posedge clk) disable iff (!resetn)
        (wr_pend_r && addr_r == OFF_SLEEP_GATE)
        |=> sleep_gate_reg_1_r == ($past(hwdata) & GATE_WMASK))
        else $error("sleep write lost");
    chk_cfg_write: assert property (@(posedge clk) disable iff (!resetn)
        (wr_pend_r && addr_r == OFF_RUN_CFG)
        |=> auto_gating_select == $past(hwdata[AUTO_GATING_BIT]))
        else $error("auto gating select write lost");
    chk_power_write: assert property (@(posedge clk) disable iff (!resetn)
        (wr_pend_r && addr_r == OFF_POWER_STATE)
        |=> power_state_r == $past(hwdata[1:0]))
        else $error("power state write lost");
    chk_deep_read: assert property (@(posedge clk) disable iff (!resetn)
        (take && !hwrite && haddr == OFF_DEEP_GATE)
        |=> hrdata == $past(deep_sleep_gate_reg_1_r))
        else $error("deep sleep read wrong");
    chk_sleep_read: assert property (@(posedge clk) disable iff (!resetn)
        (take && !hwrite && haddr == OFF_SLEEP_GATE)
        |=> hrdata == $past(sleep_gate_reg_1_r))
        else $error("sleep read wrong");
    chk_bus_okay: assert property (@(posedge clk) disable iff (!resetn)
        hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not zero-wait okay");

    // interrupt status: write one clears, a same-cycle event wins
    chk_status_clear: assert property (@(posedge clk) disable iff (!resetn)
        (wr_pend_r && addr_r == OFF_IRQ_STATUS && hwdata[IRQ_FAULT_BIT] && !fault_nxt)
        |=> !irq_status_r[IRQ_FAULT_BIT])
        else $error("fault status not cleared");
    chk_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        fault_nxt |=> irq_status_r[IRQ_FAULT_BIT])
        else $error("fault status lost to clear");
    chk_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        irq == |(irq_status_r & irq_mask_r))
        else $error("irq level wrong");

    cov_gated_fault: cover property (@(posedge clk) disable iff (!resetn) unit_fault && irq);
    cov_state_change: cover property (@(posedge clk) disable iff (!resetn) irq_status_r[IRQ_STATE_BIT]);
    cov_run_fallback: cover property (@(posedge clk) disable iff (!resetn)
        !auto_gating_select && power_state_r != PWR_RUN && gate_enable != 32'h0);
    cov_sleep_apply: cover property (@(posedge clk) disable iff (!resetn)
        auto_gating_select && power_state_r == PWR_SLEEP && gate_enable != 32'h0);
    cov_deep_apply: cover property (@(posedge clk) disable iff (!resetn)
        auto_gating_select && power_state_r == PWR_DEEP && gate_enable != 32'h0);
endmodule : peripheral_clock_gating

// ==== peripheral_clock_gating_tb_top.sv ====
// self-checking testbench for the peripheral clock gating block
`timescale 1ns/100ps
module peripheral_clock_gating_tb_top;
    import clock_gate_pkg::*;
    localparam logic [11:0] OFFS [3] = '{OFF_RUN_GATE, OFF_SLEEP_GATE, OFF_DEEP_GATE};
    logic                 clk = 1'b0;
    logic                 resetn = 1'b1;
    logic                 hsel = 1'b0;
    logic [11:0]          haddr = '0;
    logic [1:0]           htrans = 2'h0;
    logic                 hwrite = 1'b0;
    logic [31:0]          hwdata = '0;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic                 hresp;
    logic [NUM_UNITS-1:0] unit_access = '0;
    logic                 unit_fault;
    logic [NUM_UNITS-1:0] unit_clk;
    logic [31:0]          gate_enable;
    logic                 irq;
    logic [31:0]          seed = 32'hF2A6;
    logic [31:0]          rd;
    logic [31:0]          ge;
    logic [31:0]          gs [3];
    logic [1:0]           st;
    logic                 auto;
    logic                 flt;
    logic [31:0]          fi = '0;
    int                   fails = 0;
    int                   comparisons = 0;

    always #20 clk = ~clk;

    peripheral_clock_gating i_dut (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(HSIZE_WORD), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .unit_access(unit_access), .unit_fault(unit_fault), .unit_clk(unit_clk),
        .gate_enable(gate_enable), .irq(irq));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rand

    // sleep and deep sets only count once auto gating is selected
    function automatic logic [31:0] applied(input logic [1:0] s, input logic a);
        return (a ? gs[s] : gs[0]) & GATE_WMASK;
    endfunction : applied

    function automatic logic [31:0] units_of(input logic [31:0] g);
        logic [31:0] v;
        v = '0;
        for (int u = 0; u < NUM_UNITS; u++) v[u] = g[UNIT_BIT[u]];
        return v;
    endfunction : units_of

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus

    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial begin
        #1_000_000;
        fails++;
        print_verdict();
    end

    initial begin
        // a real falling edge, so the asynchronous reset branch actually runs
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        #1 check("gate_enable", gate_enable, GATE_RESET);
        check("irq", {31'h0, irq}, 32'h0);
        foreach (OFFS[r]) begin
            bus(1'b0, OFFS[r], 32'h0);
            check("gate reset", rd, GATE_RESET);
        end
        bus(1'b0, 12'h7F0, 32'h0);
        check("unmapped", rd, 32'h0);
        check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
        // walking one shows each bit position and every reserved hole
        foreach (OFFS[r]) begin
            for (int b = 0; b < 32; b++) begin
                bus(1'b1, OFFS[r], 32'h1 << b);
                bus(1'b0, OFFS[r], 32'h0);
                check("gate readback", rd, (32'h1 << b) & GATE_WMASK);
                if (r == 0) begin
                    @(posedge clk);
                    #1 check("gate_enable", gate_enable, (32'h1 << b) & GATE_WMASK);
                    @(posedge clk);
                    #10 check("unit_clk", {19'h0, unit_clk}, units_of((32'h1 << b) & GATE_WMASK));
                end
            end
        end
        repeat (20) begin
            for (int r = 0; r < 3; r++) begin
                seed = next_rand(seed);
                gs[r] = seed;
                bus(1'b1, OFFS[r], seed);
            end
            seed = next_rand(seed);
            st = 2'(seed % 3);
            auto = seed[8];
            ge = applied(st, auto);
            bus(1'b1, OFF_RUN_CFG, 32'(auto) << AUTO_GATING_BIT);
            bus(1'b1, OFF_POWER_STATE, {30'h0, st});
            bus(1'b1, OFF_IRQ_MASK, 32'h1);
            bus(1'b1, OFF_IRQ_STATUS, 32'h3);
            #1 check("gate_enable", gate_enable, ge);
            flt = 1'b0;
            for (int u = 0; u < NUM_UNITS; u++) begin
                @(posedge clk);
                unit_access <= NUM_UNITS'(1) << u;
                @(posedge clk);
                unit_access <= '0;
                flt = flt | ~ge[UNIT_BIT[u]];
                fi[u] = fi[u] | ~ge[UNIT_BIT[u]];
                #1 check("unit_fault", {31'h0, unit_fault}, {31'h0, ~ge[UNIT_BIT[u]]});
            end
            bus(1'b0, OFF_IRQ_STATUS, 32'h0);
            check("fault status", rd & 32'h1, {31'h0, flt});
            check("state status", rd & 32'h2, 32'h0);
            bus(1'b0, OFF_FAULT_INFO, 32'h0);
            check("fault info", rd, fi);
            bus(1'b1, OFF_IRQ_MASK, 32'h0);
            #1 check("irq masked", {31'h0, irq}, 32'h0);
            bus(1'b1, OFF_IRQ_MASK, 32'h1);
            #1 check("irq raised", {31'h0, irq}, {31'h0, flt});
            bus(1'b1, OFF_IRQ_STATUS, 32'h1);
            #1 check("irq cleared", {31'h0, irq}, 32'h0);
        end
        print_verdict();
    end
endmodule : peripheral_clock_gating_tb_top
